// [design/dorpm_pkg.sv]
// constants, field layout and carrier types of the output routing block
// assumes one 25 MHz datapath clock and 16-bit signed two's complement samples
//
// Summary of operation
// - bypassed: mask bit0 stream I, bit1 stream Q
// - real upconverters: mask bits pick upconverters 0-3
// - complex: bits 2,3 pick imaginary parts 0,1
// - upconverters on: all selected signals are summed per channel
// - 3-bit formats: channel B 6-4, A 2-0
// - codes 0,1,2: NRZ, return-to-inverse, return-to-zero
// - codes 3,4: interleave interpolator low/high pass
// - code 5 direct interleave, 6 off, 7 reserved
// - offset bit adds half LSB below 16 bits
// - cleared datapath enable holds datapath in reset
// - format 0 real four units, 1 complex two
package dorpm_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int SMP_W  = 16;
  localparam int ACC_W  = 18;
  localparam int MASK_W = 4;
  localparam int FMT_W  = 3;

  localparam logic [ADDR_W-1:0] ADDR_SRC  = 10'h2e4;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 10'h2e8;
  localparam logic [ADDR_W-1:0] ADDR_HLSB = 10'h2ea;

  localparam logic [DATA_W-1:0] RST_SRC  = 8'h00;
  localparam logic [DATA_W-1:0] RST_MODE = 8'h00;
  localparam logic [DATA_W-1:0] RST_HLSB = 8'h00;

  localparam int SRC1_LSB  = 4;
  localparam int SRC0_LSB  = 0;
  localparam int FMTB_LSB  = 4;
  localparam int FMTA_LSB  = 0;
  localparam int HLSB_BIT  = 0;
  localparam int IMAG_BASE = 2;

  localparam logic signed [ACC_W-1:0] SAT_HI   = 18'sh07fff;
  localparam logic signed [ACC_W-1:0] SAT_LO   = 18'sh38000;
  localparam logic signed [ACC_W-1:0] HALF_12  = 18'sh00008;
  localparam logic signed [ACC_W-1:0] HALF_8   = 18'sh00080;

  typedef enum logic [2:0] {
    FMT_NRZ    = 3'h0,
    FMT_RTI    = 3'h1,
    FMT_RTZ    = 3'h2,
    FMT_ILV_LP = 3'h3,
    FMT_ILV_HP = 3'h4,
    FMT_DIRECT = 3'h5,
    FMT_OFF    = 3'h6,
    FMT_RSVD   = 3'h7
  } dorpm_fmt_e;

  typedef enum logic [1:0] {
    RES_16 = 2'h0,
    RES_12 = 2'h1,
    RES_8  = 2'h2
  } dorpm_res_e;

  typedef struct packed {
    logic [SMP_W-1:0] even;
    logic [SMP_W-1:0] odd;
  } dorpm_pair_s;

  typedef struct packed {
    logic        en;
    dorpm_fmt_e  fmt;
    dorpm_pair_s smp;
  } dorpm_chan_s;

  typedef struct packed {
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] mode;
    logic [DATA_W-1:0] hlsb;
    logic [DATA_W-1:0] rdata;
    dorpm_chan_s [1:0] ch;
  } dorpm_state_s;

endpackage

// [design/dorpm_top.sv]
// output routing, summing and pulse-format selection for two converter channels
// assumes register strobes are one cycle, never both at once, synchronous to REF_CLK
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module dorpm_top (
  input  wire logic                         REF_CLK,       // 25 MHz datapath clock
  input  wire logic                         RST,           // async reset, high
  input  wire logic [dorpm_pkg::ADDR_W-1:0] ADDR,          // register address
  input  wire logic [dorpm_pkg::DATA_W-1:0] WDATA,         // write data
  input  wire logic                         WR,            // write strobe
  input  wire logic                         RD,            // read strobe
  output var  logic [dorpm_pkg::DATA_W-1:0] RDATA,         // read data, next cycle
  input  wire logic                         DP_ENABLE,     // datapath_enable
  input  wire logic                         UPCONV_ON,     // total_interpolation >= 2
  input  wire logic                         UPCONV_FORMAT, // upconverter_output_format
  input  wire logic [1:0]                   OUT_RES,       // output resolution select
  input  wire logic [dorpm_pkg::SMP_W-1:0]  STREAM_I,      // input stream 0
  input  wire logic [dorpm_pkg::SMP_W-1:0]  STREAM_Q,      // input stream 1
  input  wire logic [3:0][15:0]             UPC_REAL,      // upconverter real outputs
  input  wire logic [1:0][15:0]             UPC_IMAG,      // imaginary outputs 0,1
  input  wire dorpm_pkg::dorpm_pair_s [1:0] ILV_LP,        // interleave low-pass pairs
  input  wire dorpm_pkg::dorpm_pair_s [1:0] ILV_HP,        // interleave high-pass pairs
  output var  dorpm_pkg::dorpm_chan_s       OUT_CH_A,      // output_channel_a
  output var  dorpm_pkg::dorpm_chan_s       OUT_CH_B       // output_channel_b
);

  dorpm_pkg::dorpm_state_s s;
  dorpm_pkg::dorpm_state_s next_s;

  // ----------------------------------------------------------------
  // routing and summing
  // ----------------------------------------------------------------
  // one adder tree per channel; 18-bit sum saturates to 16 bits, but wraps for four full-scale terms plus the 12-bit or 8-bit offset
  function automatic logic [15:0] route_sum(input logic [3:0] m);
    logic signed [17:0] acc;
    logic signed [15:0] term;
    acc  = '0;
    term = '0;
    if (!UPCONV_ON) begin
      // no summing when bypassed: bit0 has priority
      if (m[0]) begin
        acc = 18'($signed(STREAM_I));
      end else if (m[1]) begin
        acc = 18'($signed(STREAM_Q));
      end
    end else begin
      for (int i = 0; i < dorpm_pkg::MASK_W; i++) begin
        if (UPCONV_FORMAT && i >= dorpm_pkg::IMAG_BASE) begin
          term = $signed(UPC_IMAG[i-dorpm_pkg::IMAG_BASE]);
        end else begin
          term = $signed(UPC_REAL[i]);
        end
        if (m[i]) begin
          acc = acc + 18'(term);
        end
      end
    end
    if (s.hlsb[dorpm_pkg::HLSB_BIT]) begin
      if (OUT_RES == dorpm_pkg::RES_12) begin
        acc = acc + dorpm_pkg::HALF_12;
      end else if (OUT_RES == dorpm_pkg::RES_8) begin
        acc = acc + dorpm_pkg::HALF_8;
      end
    end
    if (acc > dorpm_pkg::SAT_HI) begin
      acc = dorpm_pkg::SAT_HI;
    end else if (acc < dorpm_pkg::SAT_LO) begin
      acc = dorpm_pkg::SAT_LO;
    end
    return acc[15:0];
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0]            mask;
    dorpm_pkg::dorpm_fmt_e fmt;
    logic [15:0]           sum;
    mask   = '0;
    fmt    = dorpm_pkg::FMT_NRZ;
    sum    = '0;
    next_s = s;
    next_s.rdata = '0;
    if (WR) begin
      case (ADDR)
        dorpm_pkg::ADDR_SRC:  next_s.src  = WDATA;
        dorpm_pkg::ADDR_MODE: next_s.mode = WDATA;
        dorpm_pkg::ADDR_HLSB: next_s.hlsb = WDATA;
        default: ;
      endcase
    end
    if (RD) begin
      case (ADDR)
        dorpm_pkg::ADDR_SRC:  next_s.rdata = s.src;
        dorpm_pkg::ADDR_MODE: next_s.rdata = s.mode;
        dorpm_pkg::ADDR_HLSB: next_s.rdata = s.hlsb;
        default:              next_s.rdata = '0;
      endcase
    end
    for (int c = 0; c < 2; c++) begin
      if (c == 0) begin
        mask = s.src[dorpm_pkg::SRC0_LSB +: dorpm_pkg::MASK_W];
        fmt  = dorpm_pkg::dorpm_fmt_e'(s.mode[dorpm_pkg::FMTA_LSB +: dorpm_pkg::FMT_W]);
      end else begin
        mask = s.src[dorpm_pkg::SRC1_LSB +: dorpm_pkg::MASK_W];
        fmt  = dorpm_pkg::dorpm_fmt_e'(s.mode[dorpm_pkg::FMTB_LSB +: dorpm_pkg::FMT_W]);
      end
      sum = route_sum(mask);
      next_s.ch[c].fmt = fmt;
      next_s.ch[c].en  = 1'b1;
      case (fmt)
        // pulse shape itself is made in the analog core
        dorpm_pkg::FMT_NRZ,
        dorpm_pkg::FMT_RTI,
        dorpm_pkg::FMT_RTZ: begin
          next_s.ch[c].smp = '{even: sum, odd: sum};
        end
        dorpm_pkg::FMT_ILV_LP: begin
          next_s.ch[c].smp = ILV_LP[c];
        end
        dorpm_pkg::FMT_ILV_HP: begin
          next_s.ch[c].smp = ILV_HP[c];
        end
        dorpm_pkg::FMT_DIRECT: begin
          // partner off and factor zero left to software
          next_s.ch[c].smp = '{even: STREAM_I, odd: STREAM_Q};
        end
        default: begin
          // reserved code treated as off so it cannot emit garbage
          next_s.ch[c].en  = 1'b0;
          next_s.ch[c].smp = '0;
        end
      endcase
    end
    // settings stay; only the sample path is held
    if (!DP_ENABLE) begin
      next_s.ch = '0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s       <= '0;
      s.src   <= dorpm_pkg::RST_SRC;
      s.mode  <= dorpm_pkg::RST_MODE;
      s.hlsb  <= dorpm_pkg::RST_HLSB;
    end else begin
      s <= next_s;
    end
  end

  assign RDATA    = s.rdata;
  assign OUT_CH_A = s.ch[0];
  assign OUT_CH_B = s.ch[1];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic plain_a;
  assign plain_a = DP_ENABLE && s.mode[2:0] == 3'h0 && OUT_RES == dorpm_pkg::RES_16;

  property p_bypass_i;
    @(posedge REF_CLK) disable iff (RST)
    plain_a && !UPCONV_ON && s.src[3:0] == 4'h3 |=> OUT_CH_A.smp.even == $past(STREAM_I);
  endproperty
  a_bypass_i: assert property (p_bypass_i) else $error("bypass did not pass stream I");

  property p_real2;
    @(posedge REF_CLK) disable iff (RST)
    plain_a && UPCONV_ON && !UPCONV_FORMAT && s.src[3:0] == 4'h4
      |=> OUT_CH_A.smp.even == $past(UPC_REAL[2]);
  endproperty
  a_real2: assert property (p_real2) else $error("real output 2 not routed");

  property p_imag0;
    @(posedge REF_CLK) disable iff (RST)
    plain_a && UPCONV_ON && UPCONV_FORMAT && s.src[3:0] == 4'h4
      |=> OUT_CH_A.smp.odd == $past(UPC_IMAG[0]);
  endproperty
  a_imag0: assert property (p_imag0) else $error("imaginary part 0 not routed");

  property p_sum;
    @(posedge REF_CLK) disable iff (RST)
    plain_a && UPCONV_ON && !UPCONV_FORMAT && s.src[3:0] == 4'h3
      && UPC_REAL[0][15:14] == 2'h0 && UPC_REAL[1][15:14] == 2'h0
      |=> OUT_CH_A.smp.even == $past(UPC_REAL[0]) + $past(UPC_REAL[1]);
  endproperty
  a_sum: assert property (p_sum) else $error("channel sum wrong");

  property p_fmt_b;
    @(posedge REF_CLK) disable iff (RST)
    DP_ENABLE |=> OUT_CH_B.fmt == $past(s.mode[6:4]);
  endproperty
  a_fmt_b: assert property (p_fmt_b) else $error("channel B format field wrong");

  property p_rtz;
    @(posedge REF_CLK) disable iff (RST)
    DP_ENABLE && s.mode[2:0] == 3'h2 |=> OUT_CH_A.en && OUT_CH_A.smp.even == OUT_CH_A.smp.odd;
  endproperty
  a_rtz: assert property (p_rtz) else $error("return-to-zero channel not single rate");

  property p_ilv_hp;
    @(posedge REF_CLK) disable iff (RST)
    DP_ENABLE && s.mode[6:4] == 3'h4 |=> OUT_CH_B.smp == $past(ILV_HP[1]);
  endproperty
  a_ilv_hp: assert property (p_ilv_hp) else $error("high-pass interleave pair not used");

  property p_off;
    @(posedge REF_CLK) disable iff (RST)
    DP_ENABLE && s.mode[6:4] == 3'h6 |=> !OUT_CH_B.en && OUT_CH_B.smp == '0;
  endproperty
  a_off: assert property (p_off) else $error("disabled channel still active");

  property p_hlsb;
    @(posedge REF_CLK) disable iff (RST)
    DP_ENABLE && s.mode[2:0] == 3'h0 && !UPCONV_ON && s.src[3:0] == 4'h1 && s.hlsb[0]
      && OUT_RES == dorpm_pkg::RES_12 && STREAM_I == 16'h0000 |=> OUT_CH_A.smp.even == 16'h0008;
  endproperty
  a_hlsb: assert property (p_hlsb) else $error("half LSB offset missing");

  property p_hold;
    @(posedge REF_CLK) disable iff (RST)
    !DP_ENABLE |=> OUT_CH_A == '0 && OUT_CH_B == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("datapath not held while disabled");

  c_sum: cover property (@(posedge REF_CLK) disable iff (RST)
    DP_ENABLE && UPCONV_ON && s.src[3:0] == 4'hf);
  c_direct: cover property (@(posedge REF_CLK) disable iff (RST)
    DP_ENABLE && s.mode == 8'h55);
  c_hlsb: cover property (@(posedge REF_CLK) disable iff (RST)
    DP_ENABLE && s.hlsb[0] && OUT_RES == dorpm_pkg::RES_8);

endmodule

`default_nettype wire

// [testbench/tb_dorpm_top.sv]
// self-checking random bench of the output routing and pulse-format block
// assumes the design package and top module; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none

module tb_dorpm_top;
  logic                         REF_CLK, RST, WR, RD, DP_ENABLE, UPCONV_ON, UPCONV_FORMAT;
  logic [dorpm_pkg::ADDR_W-1:0] ADDR;
  logic [dorpm_pkg::DATA_W-1:0] WDATA, RDATA, src_sh, mode_sh, hlsb_sh;
  logic [1:0]                   OUT_RES;
  logic [dorpm_pkg::SMP_W-1:0]  STREAM_I, STREAM_Q;
  logic [3:0][15:0]             UPC_REAL;
  logic [1:0][15:0]             UPC_IMAG;
  dorpm_pkg::dorpm_pair_s [1:0] ILV_LP, ILV_HP;
  dorpm_pkg::dorpm_chan_s       OUT_CH_A, OUT_CH_B;
  int                           seed, fails, checks_done;

  dorpm_top i_dorpm_top (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .DP_ENABLE(DP_ENABLE), .UPCONV_ON(UPCONV_ON), .UPCONV_FORMAT(UPCONV_FORMAT),
    .OUT_RES(OUT_RES), .STREAM_I(STREAM_I), .STREAM_Q(STREAM_Q), .UPC_REAL(UPC_REAL),
    .UPC_IMAG(UPC_IMAG), .ILV_LP(ILV_LP), .ILV_HP(ILV_HP), .OUT_CH_A(OUT_CH_A), .OUT_CH_B(OUT_CH_B));

  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  // ----------------------------------------------------------------
  // expectation and comparison
  // ----------------------------------------------------------------
  function automatic dorpm_pkg::dorpm_chan_s model(input int c);
    dorpm_pkg::dorpm_chan_s r;
    logic signed [17:0]     s;
    logic [3:0]             m;
    logic [2:0]             f;
    m = src_sh[c*4 +: 4];
    f = mode_sh[c*4 +: 3];
    s = 18'sh0;
    if (!UPCONV_ON) begin
      // bypass never sums; stream I takes priority
      s = m[0] ? 18'($signed(STREAM_I)) : m[1] ? 18'($signed(STREAM_Q)) : 18'sh0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (m[k]) s = s + ((UPCONV_FORMAT && k > 1) ? 18'($signed(UPC_IMAG[k[0]])) : 18'($signed(UPC_REAL[k])));
      end
    end
    if (hlsb_sh[0]) s = s + (OUT_RES == 2'h1 ? 18'sh8 : OUT_RES == 2'h2 ? 18'sh80 : 18'sh0);
    if (s > dorpm_pkg::SAT_HI) s = dorpm_pkg::SAT_HI;
    if (s < dorpm_pkg::SAT_LO) s = dorpm_pkg::SAT_LO;
    r.en = (f < 3'h6);
    r.fmt = dorpm_pkg::dorpm_fmt_e'(f);
    case (f)
      3'h0, 3'h1, 3'h2: r.smp = {s[15:0], s[15:0]};
      3'h3: r.smp = ILV_LP[c];
      3'h4: r.smp = ILV_HP[c];
      3'h5: r.smp = {STREAM_I, STREAM_Q};
      default: r.smp = '0;
    endcase
    if (!DP_ENABLE) r = '0;
    return r;
  endfunction

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a disabled or held channel must show zero samples too, not only flag and code
  task automatic cmp_ch(input dorpm_pkg::dorpm_chan_s got, input dorpm_pkg::dorpm_chan_s exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus and stream drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge REF_CLK);
    WR    <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge REF_CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge REF_CLK);
    RD   <= 1'b0;
    @(negedge REF_CLK);
    cmp8(RDATA, exp);
    @(negedge REF_CLK);
    cmp8(RDATA, 8'h00);
  endtask

  task automatic run(input int n);
    dorpm_pkg::dorpm_chan_s ea, eb;
    @(negedge REF_CLK);
    ea = model(0);
    eb = model(1);
    repeat (n) begin
      @(posedge REF_CLK);
      STREAM_I  <= 16'($random(seed));
      STREAM_Q  <= 16'($random(seed));
      UPC_REAL  <= ($random(seed) % 4 == 0) ? {4{16'h7fff}} : {$random(seed), $random(seed)};
      UPC_IMAG  <= 32'($random(seed));
      ILV_LP    <= {$random(seed), $random(seed)};
      ILV_HP    <= {$random(seed), $random(seed)};
      OUT_RES   <= 2'($random(seed));
      DP_ENABLE <= ($random(seed) % 8 != 0);
      @(negedge REF_CLK);
      cmp_ch(OUT_CH_A, ea);
      cmp_ch(OUT_CH_B, eb);
      ea = model(0);
      eb = model(1);
    end
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] a, b;
    logic [3:0] m0, m1;
    seed = 32'hb5a7;
    fails = 0;
    checks_done = 0;
    {RST, WR, RD, DP_ENABLE, UPCONV_ON, UPCONV_FORMAT, OUT_RES} = 8'h80;
    {ADDR, WDATA, STREAM_I, STREAM_Q, UPC_REAL, UPC_IMAG, ILV_LP, ILV_HP} = '0;
    {src_sh, mode_sh, hlsb_sh} = '0;
    repeat (20) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(dorpm_pkg::ADDR_SRC, dorpm_pkg::RST_SRC);
    rd(dorpm_pkg::ADDR_MODE, dorpm_pkg::RST_MODE);
    rd(dorpm_pkg::ADDR_HLSB, dorpm_pkg::RST_HLSB);
    for (int i = 0; i < 64; i++) begin
      @(posedge REF_CLK);
      DP_ENABLE     <= 1'b0;
      UPCONV_FORMAT <= 1'($random(seed));
      a = 3'(i);
      b = 3'($random(seed));
      if (a == 3'h5 && b != 3'h5) b = 3'h5 + 3'($random(seed) & 1);
      if (b == 3'h5 && a != 3'h5) a = 3'h5 + 3'($random(seed) & 1);
      UPCONV_ON <= (a != 3'h5 && b != 3'h5 && $random(seed) % 2 == 0);
      @(posedge REF_CLK);
      m0 = UPCONV_ON ? 4'($random(seed)) : 4'h1 << ($random(seed) & 1);
      m1 = UPCONV_ON ? 4'($random(seed)) : 4'h1 << ($random(seed) & 1);
      if (UPCONV_FORMAT && UPCONV_ON) m0 = m0 & (m0[0] ? 4'h3 : 4'hc);
      if (UPCONV_FORMAT && UPCONV_ON) m1 = m1 & (m1[0] ? 4'h3 : 4'hc);
      src_sh  = {m1, m0};
      mode_sh = {1'($random(seed)), b, 1'($random(seed)), a};
      hlsb_sh = 8'($random(seed));
      wr(dorpm_pkg::ADDR_SRC, src_sh);
      wr(dorpm_pkg::ADDR_MODE, mode_sh);
      wr(dorpm_pkg::ADDR_HLSB, hlsb_sh);
      wr(10'h2e6, 8'($random(seed)));
      rd(dorpm_pkg::ADDR_SRC, src_sh);
      rd(dorpm_pkg::ADDR_MODE, mode_sh);
      rd(dorpm_pkg::ADDR_HLSB, hlsb_sh);
      rd(10'h2e6, 8'h00);
      @(posedge REF_CLK);
      DP_ENABLE <= 1'b1;
      run(12);
    end
    // mid-run reset with non-default settings stored must restore every register
    @(posedge REF_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(dorpm_pkg::ADDR_SRC, dorpm_pkg::RST_SRC);
    rd(dorpm_pkg::ADDR_MODE, dorpm_pkg::RST_MODE);
    rd(dorpm_pkg::ADDR_HLSB, dorpm_pkg::RST_HLSB);
    tally_and_finish;
  end
endmodule

`default_nettype wire
